// *** design/uart_rx_regs.svh ***
// register offsets, field positions, reset values and timing counts of the receiver
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

// ***********
// offsets
// ***********
`define OFS_STATUS 8'h00
`define OFS_DATA 8'h04
`define OFS_CTRL1 8'h08
`define OFS_CTRL2 8'h0C
`define OFS_BAUD 8'h10
`define OFS_RX_FINE 8'h14
`define OFS_TX_FINE 8'h18

// ***********
// status fields
// ***********
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAME 1
`define ST_PARITY 0

// ***********
// control fields
// ***********
`define C1_BIT9 7
`define C1_TX_BIT9 6
`define C1_LONG 4
`define C1_WAKE 3
`define C1_PAR_ON 2
`define C1_PAR_ODD 1
`define C1_PAR_IRQ 0
`define C2_RX_IRQ 5
`define C2_IDLE_IRQ 4
`define C2_RX_EN 2
`define C2_MUTE 1
`define BAUD_COARSE 7:6
`define BAUD_TX 5:3
`define BAUD_RX 2:0

// ***********
// values and counts
// ***********
`define RST_REG 8'h00
`define COARSE_1 4'h1
`define COARSE_3 4'h3
`define COARSE_4 4'h4
`define COARSE_13 4'hD
`define OVERSAMPLE 5'h10
`define SAMPLE_LAST 4'hF
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define IDLE_TICKS_8 8'hA0
`define IDLE_TICKS_9 8'hB0
`define BITS_8 4'h8
`define BITS_9 4'h9
`define BREAK_DATA 8'h00

`endif

// *** design/uart_rx_pkg.sv ***
// types shared by the receiver block
package uart_rx_pkg;
  typedef enum logic [1:0] {
    HUNT,
    START,
    DATA,
    STOP
  } rx_state_t;
  typedef logic [7:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;
endpackage : uart_rx_pkg

// *** design/uart_rx.sv ***
// uart receiver with baud generation, mute and wake-up, parity and apb registers
`timescale 1ns/1ps
`include "uart_rx_regs.svh"

module uart_rx (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire uart_rx_pkg::apb_addr_t PADDR,
  input wire uart_rx_pkg::apb_data_t PWDATA,
  output uart_rx_pkg::apb_data_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial line and cpu mask
  input wire logic RXD,
  input wire logic [1:0] IRQ_MASK,
  // outputs
  output logic IRQ,
  output logic TX_BAUD_TICK,
  output logic TX_LOAD,
  output logic [8:0] TX_WORD
);
  import uart_rx_pkg::*;

  // ***********
  // helpers
  // ***********
  function automatic logic odd_ones(input logic [8:0] w, input logic long_word);
    odd_ones = long_word ? ^w[7:0] : ^w[6:0];
  endfunction : odd_ones

  function automatic logic [6:0] pow2_limit(input logic [2:0] sel);
    pow2_limit = 7'((8'h01 << sel) - 8'h01);
  endfunction : pow2_limit

  // ***********
  // registers
  // ***********
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] baud_reg;
  logic [7:0] rx_fine_div_reg;
  logic [7:0] tx_fine_div_reg;
  logic [7:0] rx_buffer;
  logic rx_full_flag, idle_flag, overrun_flag, noise_flag, frame_err_flag, parity_err_flag;
  logic clear_armed;
  logic long_word, parity_on, parity_odd_sel, rx_enable, mute_ctrl;

  assign long_word = ctrl1[`C1_LONG];
  assign parity_on = ctrl1[`C1_PAR_ON];
  assign parity_odd_sel = ctrl1[`C1_PAR_ODD];
  assign rx_enable = ctrl2[`C2_RX_EN];
  assign mute_ctrl = ctrl2[`C2_MUTE];

  logic setup, access, wr_en, rd_en, mapped;
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & PREADY;
  assign wr_en = access & PWRITE;
  assign rd_en = access & ~PWRITE;
  assign mapped = (PADDR == `OFS_STATUS) || (PADDR == `OFS_DATA) || (PADDR == `OFS_CTRL1) ||
                  (PADDR == `OFS_CTRL2) || (PADDR == `OFS_BAUD) ||
                  (PADDR == `OFS_RX_FINE) || (PADDR == `OFS_TX_FINE);

  // events from the receiver
  logic char_done, idle_seen, wake_idle, wake_mark;
  logic [8:0] shift;
  logic noise_acc, stop_bad;
  logic rx_buffer_load;

  logic [7:0] status;
  assign status = {2'b00, rx_full_flag, idle_flag, overrun_flag, noise_flag, frame_err_flag,
                   parity_err_flag};

  // ***********
  // apb slave
  // ***********
  // data is registered during setup, so exactly one access cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~mapped;
      if (setup & ~PWRITE) begin
        case (PADDR)
          `OFS_STATUS: PRDATA <= {24'h000000, status};
          `OFS_DATA: PRDATA <= {24'h000000, rx_buffer};
          `OFS_CTRL1: PRDATA <= {24'h000000, ctrl1};
          `OFS_CTRL2: PRDATA <= {24'h000000, ctrl2};
          `OFS_BAUD: PRDATA <= {24'h000000, baud_reg};
          `OFS_RX_FINE: PRDATA <= {24'h000000, rx_fine_div_reg};
          `OFS_TX_FINE: PRDATA <= {24'h000000, tx_fine_div_reg};
          default: PRDATA <= '0;
        endcase
      end
    end
  end

  // baud registers written freely; software keeps them still while enabled
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl1 <= `RST_REG;
      ctrl2 <= `RST_REG;
      baud_reg <= `RST_REG;
      rx_fine_div_reg <= `RST_REG;
      tx_fine_div_reg <= `RST_REG;
    end else begin
      if (wr_en && PADDR == `OFS_CTRL1) begin
        ctrl1[6:0] <= PWDATA[6:0];
      end
      if (char_done && rx_buffer_load) begin
        ctrl1[`C1_BIT9] <= long_word & shift[8];
      end
      if (wr_en && PADDR == `OFS_CTRL2) begin
        ctrl2 <= PWDATA[7:0];
      end
      if (wake_idle | wake_mark) begin
        ctrl2[`C2_MUTE] <= 1'b0;
      end
      if (wr_en && PADDR == `OFS_BAUD) begin
        baud_reg <= PWDATA[7:0];
      end
      if (wr_en && PADDR == `OFS_RX_FINE) begin
        rx_fine_div_reg <= PWDATA[7:0];
      end
      if (wr_en && PADDR == `OFS_TX_FINE) begin
        tx_fine_div_reg <= PWDATA[7:0];
      end
    end
  end

  // ***********
  // baud generation
  // ***********
  logic [3:0] coarse_cnt, baud_div_coarse;
  logic [6:0] rx_rate_cnt, tx_rate_cnt;
  logic [7:0] rx_fine_cnt, tx_fine_cnt;
  logic [3:0] tx_os_cnt;
  logic coarse_tick, rx_rate_tick, tx_rate_tick, rx_tick, tx_fine_tick;

  always_comb begin
    case (baud_reg[`BAUD_COARSE])
      2'b00: baud_div_coarse = `COARSE_1;
      2'b01: baud_div_coarse = `COARSE_3;
      2'b10: baud_div_coarse = `COARSE_4;
      default: baud_div_coarse = `COARSE_13;
    endcase
  end

  assign coarse_tick = (coarse_cnt == 4'(baud_div_coarse - 4'h1));
  assign rx_rate_tick = coarse_tick && (rx_rate_cnt == pow2_limit(baud_reg[`BAUD_RX]));
  assign tx_rate_tick = coarse_tick && (tx_rate_cnt == pow2_limit(baud_reg[`BAUD_TX]));
  assign rx_tick = rx_rate_tick &&
                   (rx_fine_div_reg == 8'h00 || rx_fine_cnt == 8'(rx_fine_div_reg - 8'h01));
  assign tx_fine_tick = tx_rate_tick &&
                   (tx_fine_div_reg == 8'h00 || tx_fine_cnt == 8'(tx_fine_div_reg - 8'h01));

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      coarse_cnt <= '0;
      rx_rate_cnt <= '0;
      tx_rate_cnt <= '0;
      rx_fine_cnt <= '0;
      tx_fine_cnt <= '0;
      tx_os_cnt <= '0;
      TX_BAUD_TICK <= 1'b0;
    end else begin
      coarse_cnt <= coarse_tick ? 4'h0 : 4'(coarse_cnt + 4'h1);
      if (coarse_tick) begin
        rx_rate_cnt <= rx_rate_tick ? 7'h00 : 7'(rx_rate_cnt + 7'h01);
        tx_rate_cnt <= tx_rate_tick ? 7'h00 : 7'(tx_rate_cnt + 7'h01);
      end
      if (rx_rate_tick) begin
        rx_fine_cnt <= rx_tick ? 8'h00 : 8'(rx_fine_cnt + 8'h01);
      end
      if (tx_rate_tick) begin
        tx_fine_cnt <= tx_fine_tick ? 8'h00 : 8'(tx_fine_cnt + 8'h01);
      end
      // final divide by sixteen for transmit
      if (tx_fine_tick) begin
        tx_os_cnt <= 4'(tx_os_cnt + 4'h1);
      end
      TX_BAUD_TICK <= tx_fine_tick && (tx_os_cnt == `SAMPLE_LAST);
    end
  end

  // ***********
  // receive sequencer
  // ***********
  rx_state_t state;
  logic [3:0] os_cnt, bit_cnt, nbits;
  logic [2:0] votes;
  logic line_prev, vote, idle_armed;
  logic [7:0] idle_cnt, idle_len;

  // data bits including any parity bit
  assign nbits = long_word ? `BITS_9 : `BITS_8;
  assign idle_len = long_word ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
  assign vote = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= HUNT;
      os_cnt <= '0;
      bit_cnt <= '0;
      votes <= '0;
      shift <= '0;
      noise_acc <= 1'b0;
      stop_bad <= 1'b0;
      line_prev <= 1'b1;
      char_done <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (!rx_enable) begin
        state <= HUNT;
        line_prev <= 1'b1;
      end else if (rx_tick) begin
        line_prev <= RXD;
        if (os_cnt == `SAMPLE_A || os_cnt == `SAMPLE_B || os_cnt == `SAMPLE_C) begin
          votes <= {votes[1:0], RXD};
        end
        os_cnt <= 4'(os_cnt + 4'h1);
        case (state)
          HUNT: begin
            os_cnt <= 4'h1;
            if (line_prev && !RXD) begin
              state <= START;
              shift <= '0;
              noise_acc <= 1'b0;
              bit_cnt <= '0;
            end
          end
          START: begin
            if (os_cnt == `SAMPLE_LAST) begin
              state <= vote ? HUNT : DATA;
              line_prev <= 1'b1;
            end
          end
          DATA: begin
            if (os_cnt == `SAMPLE_LAST) begin
              shift[bit_cnt] <= vote;
              bit_cnt <= 4'(bit_cnt + 4'h1);
              if (bit_cnt == 4'(nbits - 4'h1)) begin
                state <= STOP;
              end
            end
          end
          STOP: begin
            // decide mid-stop so the next start edge is not missed
            if (os_cnt == 4'(`SAMPLE_C + 4'h1)) begin
              stop_bad <= ~vote;
              char_done <= 1'b1;
              state <= HUNT;
              line_prev <= vote;
            end
          end
          default: state <= HUNT;
        endcase
        if (state != HUNT && os_cnt == `SAMPLE_LAST && (votes == 3'b011 || votes == 3'b101 ||
            votes == 3'b110 || votes == 3'b001 || votes == 3'b010 || votes == 3'b100)) begin
          noise_acc <= 1'b1;
        end
      end
    end
  end

  // idle line: ten or eleven high bit times
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      idle_cnt <= '0;
      idle_armed <= 1'b1;
      idle_seen <= 1'b0;
    end else begin
      idle_seen <= 1'b0;
      if (!rx_enable || state != HUNT || (rx_tick && !RXD)) begin
        idle_cnt <= '0;
      end else if (rx_tick && idle_cnt != idle_len) begin
        idle_cnt <= 8'(idle_cnt + 8'h01);
        if (8'(idle_cnt + 8'h01) == idle_len && idle_armed) begin
          idle_seen <= 1'b1;
        end
      end
      // only one idle event per quiet spell
      if (char_done) begin
        idle_armed <= 1'b1;
      end else if (idle_seen) begin
        idle_armed <= 1'b0;
      end
    end
  end

  // ***********
  // flags and buffer
  // ***********
  logic wake_msb, parity_bad, accept, do_clear;
  // data msb, skipping the parity position
  assign wake_msb = parity_on ? shift[4'(nbits - 4'h2)] : shift[4'(nbits - 4'h1)];
  // parity check over low bits plus parity
  assign parity_bad = parity_on &&
                      ((odd_ones(shift, long_word) ^ shift[4'(nbits - 4'h1)]) != parity_odd_sel);
  // address mark wakes and is received
  assign wake_mark = char_done && mute_ctrl && ctrl1[`C1_WAKE] && wake_msb;
  assign wake_idle = idle_seen && mute_ctrl && !ctrl1[`C1_WAKE];
  assign accept = char_done && (!mute_ctrl || wake_mark);
  assign rx_buffer_load = !rx_full_flag && (!mute_ctrl || wake_mark);
  assign do_clear = rd_en && PADDR == `OFS_DATA && clear_armed;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      clear_armed <= 1'b0;
    end else if (access && PADDR == `OFS_STATUS) begin
      clear_armed <= 1'b1;
    end else if (rd_en && PADDR == `OFS_DATA) begin
      clear_armed <= 1'b0;
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_buffer <= `BREAK_DATA;
      rx_full_flag <= 1'b0;
      idle_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      frame_err_flag <= 1'b0;
      parity_err_flag <= 1'b0;
    end else begin
      if (do_clear) begin
        rx_full_flag <= 1'b0;
        idle_flag <= 1'b0;
        overrun_flag <= 1'b0;
        noise_flag <= 1'b0;
        frame_err_flag <= 1'b0;
        parity_err_flag <= 1'b0;
      end
      if (accept && rx_full_flag) begin
        // overrun keeps buffer, sets only overrun and full
        overrun_flag <= 1'b1;
        rx_full_flag <= 1'b1;
      end else if (accept) begin
        rx_buffer <= shift[7:0];
        rx_full_flag <= 1'b1;
        noise_flag <= noise_acc;
        frame_err_flag <= stop_bad;
        parity_err_flag <= parity_bad;
      end
      // idle uses the same flag sequence
      if (idle_seen && !mute_ctrl) begin
        idle_flag <= 1'b1;
      end
    end
  end

  // ***********
  // interrupt request
  // ***********
  // enables gated by cpu mask
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (IRQ_MASK == 2'b00) &&
             ((ctrl2[`C2_RX_IRQ] && (rx_full_flag || overrun_flag)) ||
              (ctrl2[`C2_IDLE_IRQ] && idle_flag) ||
              (ctrl1[`C1_PAR_IRQ] && parity_err_flag));
    end
  end

  // ***********
  // transmit word with parity
  // ***********
  // parity replaces the data msb
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TX_WORD <= '0;
      TX_LOAD <= 1'b0;
    end else begin
      TX_LOAD <= wr_en && PADDR == `OFS_DATA;
      if (wr_en && PADDR == `OFS_DATA) begin
        case ({long_word, parity_on})
          2'b01: TX_WORD <= {1'b0, odd_ones(9'(PWDATA[6:0]), 1'b0) ^ parity_odd_sel,
                             PWDATA[6:0]};
          2'b10: TX_WORD <= {ctrl1[`C1_TX_BIT9], PWDATA[7:0]};
          2'b11: TX_WORD <= {odd_ones(9'(PWDATA[7:0]), 1'b1) ^ parity_odd_sel, PWDATA[7:0]};
          default: TX_WORD <= {1'b0, PWDATA[7:0]};
        endcase
      end
    end
  end
endmodule : uart_rx

// *** dv/uart_rx_chk.sv ***
// port checker for the uart receiver, bound to its top module
`timescale 1ns/1ps
module uart_rx_chk (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire uart_rx_pkg::apb_addr_t PADDR,
  input wire uart_rx_pkg::apb_data_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // mask and outputs
  input wire logic [1:0] IRQ_MASK,
  input wire logic IRQ,
  input wire logic TX_BAUD_TICK,
  input wire logic TX_LOAD
);
  import uart_rx_pkg::*;
  // ***********
  // properties
  // ***********
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence s_data_write;
    s_access ##0 (PWRITE && PADDR == 8'h04);
  endsequence
  chk_ready_next: assert property (s_setup |=> PREADY)
    else $error("ready missing after setup");
  chk_ready_once: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("ready outside first access cycle");
  chk_err_ready: assert property (PSLVERR |-> s_access)
    else $error("slave error without ready");
  chk_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_load_after: assert property (s_data_write |-> ##[1:2] TX_LOAD)
    else $error("no load after data write");
  chk_load_pulse: assert property (TX_LOAD |=> !TX_LOAD)
    else $error("load longer than a cycle");
  chk_tick_pulse: assert property (TX_BAUD_TICK |=> !TX_BAUD_TICK)
    else $error("baud tick longer than a cycle");
  chk_irq_mask: assert property (IRQ |-> $past(IRQ_MASK) == 2'b00)
    else $error("interrupt through cpu mask");
  chk_reset_quiet: assert property (disable iff (1'b0) RST |=> !IRQ && !PREADY && !TX_LOAD)
    else $error("outputs active after reset");
endmodule : uart_rx_chk

bind uart_rx uart_rx_chk u_chk (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .PSLVERR, .IRQ_MASK, .IRQ, .TX_BAUD_TICK, .TX_LOAD);

// *** dv/uart_line_model.sv ***
// behavioural far-end transmitter driving the receive line
`timescale 1ns/1ps
module uart_line_model (
  // clock
  input wire logic clk,
  // serial line, idle high
  output logic line
);
  // ***********
  // framing
  // ***********
  initial line = 1'b1;
  task automatic send(input logic [8:0] word, input int nbits, input logic stop_val,
    input int bit_clks, input int glitch_bit);
    logic val;
    for (int i = 0; i < nbits + 2; i++) begin
      val = (i == 0) ? 1'b0 : (i > nbits) ? stop_val : word[i - 1];
      for (int t = 0; t < bit_clks; t++) begin
        @(posedge clk);
        line <= (i == glitch_bit && t == 8) ? ~val : val;
      end
    end
    @(posedge clk);
    line <= 1'b1;
  endtask : send
endmodule : uart_line_model

// *** dv/tb_uart_receiver_baud_wake_parity.sv ***
// self-checking bench for the uart receiver
`timescale 1ns/1ps
`include "uart_rx_regs.svh"
module tb_uart_receiver_baud_wake_parity;
  import uart_rx_pkg::*;
  // ***********
  // bench
  // ***********
  localparam int LIMIT = 90000;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  apb_addr_t PADDR = 8'h00;
  apb_data_t PWDATA = 32'h0;
  apb_data_t PRDATA;
  logic PREADY;
  logic PSLVERR;
  wire RXD;
  logic [1:0] IRQ_MASK = 2'b00;
  logic IRQ;
  logic TX_BAUD_TICK;
  logic TX_LOAD;
  logic [8:0] TX_WORD;
  apb_data_t rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int bc = 16;
  always #5 CLK_SYS = ~CLK_SYS;
  uart_rx uut (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .RXD, .IRQ_MASK, .IRQ, .TX_BAUD_TICK, .TX_LOAD, .TX_WORD);
  uart_line_model far_tx (.clk(CLK_SYS), .line(RXD));
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input apb_addr_t a, input logic [7:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // no local limit: this wait ends on PREADY, or else at the bench timeout
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input apb_addr_t a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdck(input apb_addr_t a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask : rdck
  task automatic clear();
    apb(1'b0, `OFS_STATUS, 8'h00);
    apb(1'b0, `OFS_DATA, 8'h00);
  endtask : clear
  task automatic flush();
    repeat (bc * 12) @(posedge CLK_SYS);
    clear();
  endtask : flush
  task automatic snd(input logic [8:0] w, input int nb, input logic st, input int g);
    far_tx.send(w, nb, st, bc, g);
    repeat (4) @(posedge CLK_SYS);
  endtask : snd
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (TX_BAUD_TICK !== 1'b1 && n < 9000);
  endtask : gap
  // ***********
  // scenarios
  // ***********
  task automatic t_reset();
    snd(9'h0A5, 8, 1'b1, -1);
    rdck(`OFS_STATUS, 8'h00);
    rdck(`OFS_CTRL2, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    check({31'h0, err}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_rx();
    wr(`OFS_CTRL2, 8'h34);
    snd(9'h0A5, 8, 1'b1, -1);
    check({31'h0, IRQ}, 32'h1);
    rdck(`OFS_STATUS, 8'h20);
    rdck(`OFS_DATA, 8'hA5);
    rdck(`OFS_STATUS, 8'h00);
    check({31'h0, IRQ}, 32'h0);
    repeat (bc * 12) @(posedge CLK_SYS);
    check({31'h0, IRQ}, 32'h1);
    rdck(`OFS_STATUS, 8'h10);
    rdck(`OFS_DATA, 8'hA5);
    flush();
    $display("receive test done");
  endtask : t_rx
  task automatic t_overrun();
    IRQ_MASK <= 2'b01;
    wr(`OFS_CTRL2, 8'h24);
    snd(9'h03C, 8, 1'b1, -1);
    snd(9'h0C3, 8, 1'b1, -1);
    check({31'h0, IRQ}, 32'h0);
    rdck(`OFS_STATUS, 8'h28);
    IRQ_MASK <= 2'b00;
    repeat (2) @(posedge CLK_SYS);
    check({31'h0, IRQ}, 32'h1);
    rdck(`OFS_DATA, 8'h3C);
    rdck(`OFS_STATUS, 8'h00);
    flush();
    $display("overrun test done");
  endtask : t_overrun
  task automatic t_errors();
    logic [8:0] w [3] = '{9'h055, 9'h081, 9'h000};
    logic [7:0] e [3] = '{8'h24, 8'h22, 8'h22};
    wr(`OFS_CTRL2, 8'h04);
    for (int i = 0; i < 3; i++) begin
      snd(w[i], 8, i == 0, i == 0 ? 2 : -1);
      rdck(`OFS_STATUS, e[i]);
      rdck(`OFS_DATA, w[i][7:0]);
      rdck(`OFS_STATUS, 8'h00);
    end
    flush();
    $display("error test done");
  endtask : t_errors
  task automatic t_parity();
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CTRL1, i[1] ? 8'h07 : 8'h05);
      snd(i[0] ? 9'h0B5 : 9'h035, 8, 1'b1, -1);
      // even select wants an even total of ones, odd select an odd total
      e = (i[1] != i[0]) ? 8'h21 : 8'h20;
      check({31'h0, IRQ}, {31'h0, e[0]});
      rdck(`OFS_STATUS, e);
      clear();
    end
    wr(`OFS_CTRL1, 8'h14);
    snd(9'h034, 9, 1'b1, -1);
    rdck(`OFS_STATUS, 8'h21);
    rdck(`OFS_CTRL1, 8'h14);
    clear();
    wr(`OFS_CTRL1, 8'h10);
    snd(9'h1A5, 9, 1'b1, -1);
    rdck(`OFS_CTRL1, 8'h90);
    rdck(`OFS_STATUS, 8'h20);
    rdck(`OFS_DATA, 8'hA5);
    flush();
    $display("parity test done");
  endtask : t_parity
  task automatic t_tx();
    logic [7:0] c [3] = '{8'h04, 8'h06, 8'h50};
    logic [7:0] d [3] = '{8'hB5, 8'hB5, 8'h3C};
    logic [8:0] e [3] = '{9'h035, 9'h0B5, 9'h13C};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_CTRL1, c[i]);
      wr(`OFS_DATA, d[i]);
      n = 0;
      while (TX_LOAD !== 1'b1 && n < 8) begin
        @(posedge CLK_SYS);
        n++;
      end
      check({31'h0, TX_LOAD}, 32'h1);
      check({23'h0, TX_WORD}, {23'h0, e[i]});
    end
    $display("transmit word test done");
  endtask : t_tx
  task automatic t_mute();
    wr(`OFS_CTRL1, 8'h00);
    wr(`OFS_CTRL2, 8'h36);
    snd(9'h0F0, 8, 1'b1, -1);
    check({31'h0, IRQ}, 32'h0);
    rdck(`OFS_STATUS, 8'h00);
    repeat (bc * 12) @(posedge CLK_SYS);
    rdck(`OFS_CTRL2, 8'h34);
    rdck(`OFS_STATUS, 8'h00);
    wr(`OFS_CTRL1, 8'h0C);
    wr(`OFS_CTRL2, 8'h06);
    snd(9'h081, 8, 1'b1, -1);
    rdck(`OFS_STATUS, 8'h00);
    snd(9'h0C0, 8, 1'b1, -1);
    rdck(`OFS_CTRL2, 8'h04);
    rdck(`OFS_STATUS, 8'h20);
    flush();
    $display("mute test done");
  endtask : t_mute
  task automatic t_baud();
    logic [7:0] b [6] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h38, 8'h08};
    logic [7:0] f [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
    int p [6] = '{16, 48, 64, 208, 2048, 8160};
    int n;
    wr(`OFS_CTRL1, 8'h00);
    wr(`OFS_CTRL2, 8'h00);
    wr(`OFS_BAUD, 8'h41);
    wr(`OFS_RX_FINE, 8'h02);
    bc = 192;
    wr(`OFS_CTRL2, 8'h04);
    snd(9'h05A, 8, 1'b1, -1);
    rdck(`OFS_STATUS, 8'h20);
    rdck(`OFS_DATA, 8'h5A);
    wr(`OFS_CTRL2, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_BAUD, b[i]);
      wr(`OFS_TX_FINE, f[i]);
      gap(n);
      gap(n);
      check(32'(n), 32'(p[i]));
    end
    $display("baud test done");
  endtask : t_baud
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    t_rx();
    t_overrun();
    t_errors();
    t_parity();
    t_tx();
    t_mute();
    t_baud();
    stop_test();
  end
endmodule : tb_uart_receiver_baud_wake_parity
